// ### hdl/pfs_pkg.sv
// Shared constants, register map and carrier types of the forced-stop PWM
package pfs_pkg;

  // **************************************************************
  // Timing
  // **************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int PWM_PERIOD_NS = 20000;
  localparam int DUTY_PCT      = 50;
  localparam int PERIOD_CYC    = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DUTY_CYC      = PERIOD_CYC * DUTY_PCT / 100;

  // **************************************************************
  // Register offsets (byte addresses)
  // **************************************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_PERIOD   = 8'h04;
  localparam logic [7:0]  ADDR_DUTY     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
  localparam logic [7:0]  ADDR_INT_STAT = 8'h10;
  localparam logic [7:0]  ADDR_INT_MASK = 8'h14;
  localparam logic [7:0]  ADDR_COUNT    = 8'h18;

  // **************************************************************
  // Field positions
  // **************************************************************
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_REL1_BIT = 1;
  localparam int ST_STOP1_BIT  = 0;
  localparam int ST_STOP2_BIT  = 1;
  localparam int ST_CMP_BIT    = 2;
  localparam int ST_FSTOP_BIT  = 3;
  localparam int ST_RUN_BIT    = 4;
  localparam int ST_REL1_BIT   = 5;
  localparam int ST_ARM2_BIT   = 6;
  localparam int IRQ_STOP1_BIT = 0;
  localparam int IRQ_STOP2_BIT = 1;
  localparam int IRQ_RSTRT_BIT = 2;
  localparam int IRQ_PERIOD_BIT = 3;
  localparam int IRQ_W         = 4;
  localparam int CNT_W         = 16;
  localparam int PIN_W         = 3;

  // **************************************************************
  // Values after reset
  // **************************************************************
  localparam logic [CNT_W-1:0] PERIOD_RST = CNT_W'(PERIOD_CYC);
  localparam logic [CNT_W-1:0] DUTY_RST   = CNT_W'(DUTY_CYC);
  localparam logic [IRQ_W-1:0] MASK_RST   = 4'h0;
  localparam logic [PIN_W-1:0] SYNC_RST   = 3'h0;

  // **************************************************************
  // Bus answers
  // **************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // **************************************************************
  // Types
  // **************************************************************
  typedef enum logic [1:0] {
    S1_IDLE = 2'b00,
    S1_HELD = 2'b01,
    S1_REL  = 2'b10
  } pfs_s1_t;

  typedef enum logic [1:0] {
    S2_IDLE  = 2'b00,
    S2_HELD  = 2'b01,
    S2_ARMED = 2'b10
  } pfs_s2_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pfs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pfs_axi_rsp_t;

  typedef struct packed {
    logic analog_comparator;
    logic forced_stop_irq_pin;
    logic restart_irq_pin;
  } pfs_pins_t;

  typedef struct packed {
    logic level;
    logic oe;
  } pfs_pwm_t;

endpackage

// ### hdl/pfs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module pfs_sync (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Pins from outside the clock domain
  input  wire pfs_pkg::pfs_pins_t pins_raw,
  // Filtered levels
  output      pfs_pkg::pfs_pins_t pins_stable
);

  typedef struct packed {
    logic [pfs_pkg::PIN_W-1:0] s1;
    logic [pfs_pkg::PIN_W-1:0] s2;
    logic [pfs_pkg::PIN_W-1:0] s3;
    logic [pfs_pkg::PIN_W-1:0] stable;
  } pfs_sync_state_t;

  pfs_sync_state_t           q_r;
  pfs_sync_state_t           q_nxt;
  logic [pfs_pkg::PIN_W-1:0] raw_v;
  logic [pfs_pkg::PIN_W-1:0] upd_v;

  assign raw_v = pins_raw;

  // Level moves only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < pfs_pkg::PIN_W; gi = gi + 1) begin : g_bit
      assign upd_v[gi] = (q_r.s2[gi] == q_r.s3[gi]) ? q_r.s3[gi]
                                                    : q_r.stable[gi];
    end
  endgenerate

  // Shift chain; first stage feeds only the second
  always_comb begin
    q_nxt        = q_r;
    q_nxt.s1     = raw_v;
    q_nxt.s2     = q_r.s1;
    q_nxt.s3     = q_r.s2;
    q_nxt.stable = upd_v;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '{pfs_pkg::SYNC_RST, pfs_pkg::SYNC_RST,
               pfs_pkg::SYNC_RST, pfs_pkg::SYNC_RST};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pins_stable = q_r.stable;

endmodule

// ### hdl/pfs_pwm_forced_stop.sv
// PWM timer channel with two hardware forced-stop paths, AXI4-Lite regs
`timescale 1ns/100ps

module pfs_pwm_forced_stop (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite register port
  input  wire pfs_pkg::pfs_axi_req_t axi_req,
  output      pfs_pkg::pfs_axi_rsp_t axi_rsp,
  // Comparator and interrupt pins
  input  wire pfs_pkg::pfs_pins_t    pins_raw,
  // PWM pin, level and drive enable
  output      pfs_pkg::pfs_pwm_t     pwm_out_pin,
  // Interrupt
  output      logic                  irq
);

  // **************************************************************
  // State
  // **************************************************************
  typedef struct packed {
    pfs_pkg::pfs_axi_rsp_t       rsp;
    logic                        aw_held;
    logic [pfs_pkg::ADDR_W-1:0]  awaddr;
    logic                        w_held;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic                        run;
    logic [pfs_pkg::CNT_W-1:0]   period;
    logic [pfs_pkg::CNT_W-1:0]   duty;
    logic [pfs_pkg::IRQ_W-1:0]   int_stat;
    logic [pfs_pkg::IRQ_W-1:0]   int_mask;
    logic [pfs_pkg::CNT_W-1:0]   cnt;
    pfs_pkg::pfs_s1_t            s1;
    pfs_pkg::pfs_s2_t            s2;
    pfs_pkg::pfs_pins_t          prev;
    pfs_pkg::pfs_pwm_t           pwm;
    logic                        irq;
  } pfs_state_t;

  pfs_state_t                  q_r;
  pfs_state_t                  q_nxt;
  pfs_pkg::pfs_pins_t          pins;
  logic                        cmp_rise;
  logic                        fs_fall;
  logic                        fs_rise;
  logic                        rs_rise;
  logic [pfs_pkg::CNT_W-1:0]   period_m1;
  logic                        boundary;
  logic                        wr_go;
  logic                        wr_ok;
  logic [31:0]                 wr_word;
  logic                        rel1_wr;
  logic [pfs_pkg::IRQ_W-1:0]   w1c;
  logic [pfs_pkg::IRQ_W-1:0]   events;
  logic [31:0]                 rd_data;
  logic                        rd_ok;
  logic                        pwm_level;

  // **************************************************************
  // Pin synchronisers
  // **************************************************************
  pfs_sync u_sync (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .pins_raw    (pins_raw),
    .pins_stable (pins)
  );

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // **************************************************************
  // Next-state logic
  // **************************************************************
  always_comb begin
    q_nxt     = q_r;
    wr_go     = 1'b0;
    wr_ok     = 1'b0;
    wr_word   = 32'h0000_0000;
    rel1_wr   = 1'b0;
    w1c       = '0;
    rd_data   = 32'h0000_0000;
    rd_ok     = 1'b0;

    // Edges of filtered pins; comparator rise only, forced-stop pin both sides seen
    cmp_rise = pins.analog_comparator & ~q_r.prev.analog_comparator;
    fs_fall  = ~pins.forced_stop_irq_pin & q_r.prev.forced_stop_irq_pin;
    fs_rise  = pins.forced_stop_irq_pin & ~q_r.prev.forced_stop_irq_pin;
    rs_rise  = pins.restart_irq_pin & ~q_r.prev.restart_irq_pin;
    // Previous levels reset low, so a pin idling high shows one
    // rise after reset; only S1_IDLE reacts, if the comparator idles high
    q_nxt.prev = pins;

    // Period of zero behaves as one cycle, avoids wrap underflow
    period_m1 = (q_r.period == '0) ? '0 : q_r.period - 16'h0001;
    // A restart rise counts as a boundary and frees pending stops
    boundary  = q_r.run && ((q_r.cnt >= period_m1) || rs_rise);

    // ----- Write channel: address and data in either order -----
    if (q_r.rsp.bvalid && axi_req.bready) begin
      q_nxt.rsp.bvalid = 1'b0;
    end
    if (q_r.rsp.awready && axi_req.awvalid) begin
      q_nxt.aw_held = 1'b1;
      q_nxt.awaddr  = axi_req.awaddr;
    end
    if (q_r.rsp.wready && axi_req.wvalid) begin
      q_nxt.w_held = 1'b1;
      q_nxt.wdata  = axi_req.wdata;
      q_nxt.wstrb  = axi_req.wstrb;
    end
    if (q_nxt.aw_held && q_nxt.w_held && !q_r.rsp.bvalid) begin
      wr_go         = 1'b1;
      q_nxt.aw_held = 1'b0;
      q_nxt.w_held  = 1'b0;
    end

    // Register write decode
    if (wr_go) begin
      wr_ok = 1'b1;
      case (q_nxt.awaddr)
        pfs_pkg::ADDR_CTRL: begin
          wr_word   = merge_bytes({31'h0, q_r.run}, q_nxt.wdata,
                                  q_nxt.wstrb);
          q_nxt.run = wr_word[pfs_pkg::CTRL_RUN_BIT];
          // Release trigger is a write-one pulse, never stored
          rel1_wr   = q_nxt.wstrb[0] &
                      q_nxt.wdata[pfs_pkg::CTRL_REL1_BIT];
        end
        pfs_pkg::ADDR_PERIOD: begin
          wr_word      = merge_bytes({16'h0000, q_r.period}, q_nxt.wdata,
                                     q_nxt.wstrb);
          q_nxt.period = wr_word[pfs_pkg::CNT_W-1:0];
        end
        pfs_pkg::ADDR_DUTY: begin
          wr_word    = merge_bytes({16'h0000, q_r.duty}, q_nxt.wdata,
                                   q_nxt.wstrb);
          q_nxt.duty = wr_word[pfs_pkg::CNT_W-1:0];
        end
        pfs_pkg::ADDR_INT_STAT: begin
          if (q_nxt.wstrb[0]) begin
            w1c = q_nxt.wdata[pfs_pkg::IRQ_W-1:0];
          end
        end
        pfs_pkg::ADDR_INT_MASK: begin
          wr_word        = merge_bytes({28'h0, q_r.int_mask}, q_nxt.wdata,
                                       q_nxt.wstrb);
          q_nxt.int_mask = wr_word[pfs_pkg::IRQ_W-1:0];
        end
        pfs_pkg::ADDR_STATUS,
        pfs_pkg::ADDR_COUNT: begin
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      q_nxt.rsp.bvalid = 1'b1;
      q_nxt.rsp.bresp  = wr_ok ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
    end
    // No new address or data while an answer is waiting
    q_nxt.rsp.awready = !q_nxt.aw_held && !q_nxt.rsp.bvalid;
    q_nxt.rsp.wready  = !q_nxt.w_held && !q_nxt.rsp.bvalid;

    // ----- Read channel -----
    if (q_r.rsp.rvalid && axi_req.rready) begin
      q_nxt.rsp.rvalid = 1'b0;
    end
    if (q_r.rsp.arready && axi_req.arvalid) begin
      rd_ok = 1'b1;
      case (axi_req.araddr)
        pfs_pkg::ADDR_CTRL: begin
          rd_data[pfs_pkg::CTRL_RUN_BIT] = q_r.run;
        end
        pfs_pkg::ADDR_PERIOD: begin
          rd_data[pfs_pkg::CNT_W-1:0] = q_r.period;
        end
        pfs_pkg::ADDR_DUTY: begin
          rd_data[pfs_pkg::CNT_W-1:0] = q_r.duty;
        end
        pfs_pkg::ADDR_STATUS: begin
          // Live view of stop states, filtered pins and run, reading has no side effect
          rd_data[pfs_pkg::ST_STOP1_BIT] = (q_r.s1 != pfs_pkg::S1_IDLE);
          rd_data[pfs_pkg::ST_STOP2_BIT] = (q_r.s2 != pfs_pkg::S2_IDLE);
          rd_data[pfs_pkg::ST_CMP_BIT]   = pins.analog_comparator;
          rd_data[pfs_pkg::ST_FSTOP_BIT] = pins.forced_stop_irq_pin;
          rd_data[pfs_pkg::ST_RUN_BIT]   = q_r.run;
          rd_data[pfs_pkg::ST_REL1_BIT]  = (q_r.s1 == pfs_pkg::S1_REL);
          rd_data[pfs_pkg::ST_ARM2_BIT]  = (q_r.s2 == pfs_pkg::S2_ARMED);
        end
        pfs_pkg::ADDR_INT_STAT: begin
          rd_data[pfs_pkg::IRQ_W-1:0] = q_r.int_stat;
        end
        pfs_pkg::ADDR_INT_MASK: begin
          rd_data[pfs_pkg::IRQ_W-1:0] = q_r.int_mask;
        end
        pfs_pkg::ADDR_COUNT: begin
          rd_data[pfs_pkg::CNT_W-1:0] = q_r.cnt;
        end
        default: begin
          rd_ok = 1'b0;
        end
      endcase
      q_nxt.rsp.rvalid = 1'b1;
      q_nxt.rsp.rdata  = rd_data;
      q_nxt.rsp.rresp  = rd_ok ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
    end
    // One read in flight; next address once the answer is taken
    q_nxt.rsp.arready = !q_nxt.rsp.rvalid;

    // ----- Period counter, cleared while stopped -----
    if (!q_r.run || boundary) begin
      q_nxt.cnt = '0;
    end else begin
      q_nxt.cnt = q_r.cnt + 16'h0001;
    end

    // ----- Stop one: rise engages, armed release waits for boundary -----
    case (q_r.s1)
      pfs_pkg::S1_IDLE: begin
        if (cmp_rise) begin
          q_nxt.s1 = pfs_pkg::S1_HELD;
        end
      end
      pfs_pkg::S1_HELD: begin
        // Trigger while comparator still high is ignored
        if (rel1_wr && !pins.analog_comparator) begin
          q_nxt.s1 = pfs_pkg::S1_REL;
        end
      end
      pfs_pkg::S1_REL: begin
        // A fresh rise beats the pending release
        if (cmp_rise) begin
          q_nxt.s1 = pfs_pkg::S1_HELD;
        end else if (boundary || !q_r.run) begin
          q_nxt.s1 = pfs_pkg::S1_IDLE;
        end
      end
      default: begin
        q_nxt.s1 = pfs_pkg::S1_IDLE;
      end
    endcase

    // ----- Stop two: fall engages, rise arms self-release -----
    case (q_r.s2)
      pfs_pkg::S2_IDLE: begin
        if (fs_fall) begin
          q_nxt.s2 = pfs_pkg::S2_HELD;
        end
      end
      pfs_pkg::S2_HELD: begin
        if (fs_rise) begin
          q_nxt.s2 = pfs_pkg::S2_ARMED;
        end
      end
      pfs_pkg::S2_ARMED: begin
        if (fs_fall) begin
          q_nxt.s2 = pfs_pkg::S2_HELD;
        end else if (boundary || !q_r.run) begin
          q_nxt.s2 = pfs_pkg::S2_IDLE;
        end
      end
      default: begin
        q_nxt.s2 = pfs_pkg::S2_IDLE;
      end
    endcase

    // ----- Pin drive; float beats low when both stops are on -----
    pwm_level = q_nxt.run && (q_nxt.cnt < q_nxt.duty);
    if (q_nxt.s1 != pfs_pkg::S1_IDLE) begin
      q_nxt.pwm.level = 1'b0;
      q_nxt.pwm.oe    = 1'b0;
    end else if (q_nxt.s2 != pfs_pkg::S2_IDLE) begin
      q_nxt.pwm.level = 1'b0;
      q_nxt.pwm.oe    = 1'b1;
    end else begin
      q_nxt.pwm.level = pwm_level;
      q_nxt.pwm.oe    = 1'b1;
    end

    // ----- Sticky events, set wins over a same-cycle clear -----
    // Engage events fire on the step out of idle only
    events = '0;
    events[pfs_pkg::IRQ_STOP1_BIT]  = (q_r.s1 == pfs_pkg::S1_IDLE) &&
                                      (q_nxt.s1 != pfs_pkg::S1_IDLE);
    events[pfs_pkg::IRQ_STOP2_BIT]  = (q_r.s2 == pfs_pkg::S2_IDLE) &&
                                      (q_nxt.s2 != pfs_pkg::S2_IDLE);
    events[pfs_pkg::IRQ_RSTRT_BIT]  = q_r.run && rs_rise;
    events[pfs_pkg::IRQ_PERIOD_BIT] = boundary;
    q_nxt.int_stat = (q_r.int_stat & ~w1c) | events;
    q_nxt.irq      = |(q_nxt.int_stat & q_nxt.int_mask);
  end

  // **************************************************************
  // State register
  // **************************************************************
  // Output drives low from reset so the load never sees a glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r          <= '0;
      q_r.period   <= pfs_pkg::PERIOD_RST;
      q_r.duty     <= pfs_pkg::DUTY_RST;
      q_r.int_mask <= pfs_pkg::MASK_RST;
      q_r.pwm.oe   <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // **************************************************************
  // Outputs, all straight from the state register
  // **************************************************************
  assign axi_rsp     = q_r.rsp;
  assign pwm_out_pin = q_r.pwm;
  assign irq         = q_r.irq;

endmodule

// ### tb/pfs_pwm_forced_stop_asserts.sv
// Port-level concurrent checks of the forced-stop PWM block
`timescale 1ns/100ps

module pfs_chk (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Register bus
  input wire pfs_pkg::pfs_axi_req_t axi_req,
  input wire pfs_pkg::pfs_axi_rsp_t axi_rsp,
  // Pins
  input wire pfs_pkg::pfs_pins_t    pins_raw,
  input wire pfs_pkg::pfs_pwm_t     pwm_out_pin,
  input wire logic                  irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ********
  // Sequences
  // ********
  // Eight cycles covers the synchroniser lag with margin
  sequence s_cmp_high;
    pins_raw.analog_comparator [*8];
  endsequence
  sequence s_fpin_low;
    $fell(pins_raw.forced_stop_irq_pin) ##1
      !pins_raw.forced_stop_irq_pin [*7];
  endsequence
  sequence s_wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_rd_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence

  // ********
  // Assertions
  // ********
  a_stop1_floats: assert property (
    s_cmp_high |-> !pwm_out_pin.oe)
    else $error("comparator high but pin still driven");
  a_hiz_level_low: assert property (
    !pwm_out_pin.oe |-> !pwm_out_pin.level)
    else $error("level high while pin floats");
  a_stop2_holds: assert property (
    s_fpin_low |-> !pwm_out_pin.level)
    else $error("forced pin low but level high");
  a_write_answer: assert property (
    s_wr_taken |=> axi_rsp.bvalid)
    else $error("write answer late");
  a_read_answer: assert property (
    s_rd_taken |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_bresp_stands: assert property (
    axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped");
  a_rdata_stands: assert property (
    axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read answer dropped");
  a_write_busy: assert property (
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write accepted while answer pending");
  a_read_busy: assert property (
    axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read accepted while answer pending");
  a_irq_drop_write: assert property (
    $fell(irq) |-> $rose(axi_rsp.bvalid))
    else $error("interrupt dropped without a write");
endmodule

bind pfs_pwm_forced_stop pfs_chk u_chk (
  .aclk       (aclk),
  .aresetn    (aresetn),
  .axi_req    (axi_req),
  .axi_rsp    (axi_rsp),
  .pins_raw   (pins_raw),
  .pwm_out_pin(pwm_out_pin),
  .irq        (irq)
);

// ### tb/pfs_pin_model.sv
// Far-side model: comparator output and two interrupt pins
`timescale 1ns/100ps

module pfs_pin_model (
  // Clock
  input  wire logic               aclk,
  // Wanted levels and settle lag in cycles
  input  wire pfs_pkg::pfs_pins_t want,
  input  wire logic [3:0]         lag,
  // Levels seen by the block
  output      pfs_pkg::pfs_pins_t pins
);
  logic [3:0] wait_r;

  // Pins follow want from the first edge, still inside reset

  // Each change lands after the lag, rising and falling alike
  always @(posedge aclk) begin
    if (pins !== want && wait_r < lag) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      pins <= want;
      wait_r <= 4'h0;
    end
  end
endmodule

// ### tb/pfs_pwm_forced_stop_bench.sv
// Self-checking bench of the forced-stop PWM block
`timescale 1ns/100ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module pfs_pwm_forced_stop_bench;
  logic                  aclk;
  logic                  aresetn;
  pfs_pkg::pfs_axi_req_t req;
  pfs_pkg::pfs_axi_rsp_t rsp;
  pfs_pkg::pfs_pins_t    want;
  pfs_pkg::pfs_pins_t    pins;
  pfs_pkg::pfs_pwm_t     pwm;
  logic                  irq;
  logic [3:0]            lag;
  logic [31:0]           rdat;
  logic [1:0]            resp;
  int                    num_errors;
  int                    checks;
  int                    slow;
  int                    hi;

  pfs_pwm_forced_stop dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .pins_raw(pins), .pwm_out_pin(pwm), .irq(irq));
  pfs_pin_model u_pins (.aclk(aclk), .want(want), .lag(lag), .pins(pins));

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // ********
  // Tasks
  // ********
  // Verdict and end of run
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Write; bready held back for slow cycles to test answer hold
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= '{1'b1, a, 1'b1, d, 4'hf, slow == 0, 1'b0, 8'h00, 1'b0};
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid && req.bready) n = -1;
      else if (n >= slow) req.bready <= 1'b1;
    end while (n >= 0);
    // Both halves must be taken before the answer
    `CHK({req.awvalid, req.wvalid}, 2'b00)
    resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Read; rready held back for slow cycles
  task automatic rd(input logic [7:0] a);
    int n;
    req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, slow == 0};
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid && req.rready) n = -1;
      else if (n >= slow) req.rready <= 1'b1;
    end while (n >= 0);
    `CHK(req.arvalid, 1'b0)
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdat, e)
  endtask

  // High cycles over one ten-cycle period
  task automatic meas;
    hi = 0;
    repeat (10) begin
      @(negedge aclk);
      hi += (pwm.level === 1'b1);
    end
    @(posedge aclk);
  endtask

  // Wait, bounded, for a pin state, then compare it
  task automatic wait_pwm(input pfs_pkg::pfs_pwm_t v, input int lim);
    int n;
    n = 0;
    while (pwm !== v && n < lim) begin
      @(negedge aclk);
      n++;
    end
    `CHK(pwm, v)
    @(posedge aclk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // ********
  // Tests
  // ********
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    want = 3'h2;
    lag = 4'h0;
    num_errors = 0;
    checks = 0;
    slow = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(pwm, 2'b01)
    rchk(8'h04, 32'h3e8);
    rchk(8'h08, 32'h1f4);
    rchk(8'h14, 32'h0);
    rchk(8'h18, 32'h0);
    rchk(8'h0c, 32'h8);
    wr(8'h0c, 32'h1f);
    `CHK(resp, 2'b00)
    rchk(8'h0c, 32'h8);
    slow = 3;
    rd(8'h1c);
    `CHK(resp, 2'b10)
    wr(8'h1c, 32'h1);
    `CHK(resp, 2'b10)
    slow = 0;
    done("reset");
    // Short period keeps the run brief
    wr(8'h04, 32'ha);
    wr(8'h08, 32'h5);
    wr(8'h00, 32'h1);
    repeat (12) @(posedge aclk);
    meas;
    `CHK(hi, 5)
    `CHK(pwm.oe, 1'b1)
    done("duty");
    wr(8'h14, 32'h1);
    want.analog_comparator <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK(pwm, 2'b00)
    `CHK(irq, 1'b1)
    wr(8'h00, 32'h3);
    repeat (25) @(posedge aclk);
    `CHK(pwm.oe, 1'b0)
    want.analog_comparator <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(8'h00, 32'h3);
    wait_pwm(2'b11, 16);
    wr(8'h10, 32'h1);
    `CHK(irq, 1'b0)
    done("stop one");
    // Masked event still latches status
    lag <= 4'h2;
    wr(8'h14, 32'h0);
    want.forced_stop_irq_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    meas;
    `CHK(hi, 0)
    `CHK(pwm.oe, 1'b1)
    `CHK(irq, 1'b0)
    rd(8'h10);
    `CHK(rdat[1], 1'b1)
    want.analog_comparator <= 1'b1;
    repeat (10) @(posedge aclk);
    want.forced_stop_irq_pin <= 1'b1;
    repeat (30) @(posedge aclk);
    `CHK(pwm, 2'b00)
    rchk(8'h0c, 32'h1d);
    want.analog_comparator <= 1'b0;
    repeat (10) @(posedge aclk);
    wr(8'h00, 32'h3);
    wait_pwm(2'b11, 16);
    done("both stops");
    want.forced_stop_irq_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    meas;
    `CHK(hi, 0)
    want.forced_stop_irq_pin <= 1'b1;
    wait_pwm(2'b11, 22);
    done("stop two");
    // Long period makes an early restart visible
    wr(8'h04, 32'hc8);
    wr(8'h08, 32'h64);
    wait_pwm(2'b01, 120);
    want.restart_irq_pin <= 1'b1;
    wait_pwm(2'b11, 12);
    rd(8'h10);
    `CHK(rdat[2], 1'b1)
    done("restart");
    close_out;
  end

  // Watchdog, far beyond the expected run
  initial begin
    #400000;
    num_errors++;
    close_out;
  end
endmodule
